// file: seep_core.sv
// Serial EEPROM instruction port: decode, array, status
//
// Overview of operation
// - Array holds 32 bytes or 16 words
// - Organisation pin high gives x16, low x8
// - Reset clears programming state, disables writes
// - Four-bit op-code then 4/5 address bits
// - Skip first clock, then await start bit
// - Read 10XX, write 01XX, erase 11XX
// - Enable 0011, disable 0000, erase-all 0010
// - 0001 writes one datum everywhere
// - Read shifts dummy zero then data MSB-first
// - Sequential read streams without further dummy
// - Read address wraps to zero
// - Enable persists until disable; disabled programming ignored
// - Read works regardless of enable latch
// - Erase sets location to ones at deselect
// - Write starts on select fall
// - Single write auto-erases first
// - Erase-all sets whole array to ones
// - Write-all only clears bits, no erase
// - Busy drives low, done drives high
// - Ready stays until start bit or deselect
// - Fully static with stopped serial clock
// - Array starts all ones
// - Self-timed cycle completes within 10 ms
`timescale 1ns/100ps
module seep_core
   import seep_pkg::*;
#(
   parameter int PROG_CYCLES_P = seep_pkg::PROG_CYCLES  // Self-timed cycle length in clocks
)
(
   input  wire logic clock_i,      // Core clock, 100 MHz
   input  wire logic rst_n_i,      // Power-on reset, active low
   input  wire logic ce_i,         // Clock enable, freezes all state when low
   input  wire logic select_i,     // Chip select pin
   input  wire logic sclk_i,       // Serial clock pin
   input  wire logic din_i,        // Serial data-in pin
   input  wire logic org_i,        // Organisation pin, high or pulled up for x16
   input  wire logic unused_test_pin_i, // Test pin, no effect
   output logic      dout_o,       // Serial data-out level
   output logic      dout_oe_o,    // Data-out driven when high
   output logic      busy_o        // Self-timed cycle in progress
);
   import seep_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic sel_s;                    // Synchronised select
   logic sck_s;                    // Synchronised serial clock
   logic din_s;                    // Synchronised data-in
   logic org_s;                    // Synchronised organisation
   logic sck_d;                    // Previous serial clock, for edges

   seep_sync u_sync_sel (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .async_i(select_i), .sync_o(sel_s));
   seep_sync u_sync_sck (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .async_i(sclk_i), .sync_o(sck_s));
   seep_sync u_sync_din (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .async_i(din_i), .sync_o(din_s));
   seep_sync u_sync_org (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .async_i(org_i), .sync_o(org_s));

   // Serial clock edge history
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sck_d <= 1'b0;
      else if (ce_i)
         sck_d <= sck_s;
   end

   logic sck_rise;                 // Rising serial clock edge seen
   logic sel_d;                    // Previous select
   logic sel_fall;                 // Select just dropped
   assign sck_rise = sck_s & ~sck_d;
   assign sel_fall = sel_d & ~sel_s;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Address width for the organisation
   function automatic logic [4:0] addr_len(input logic x16);
      addr_len = x16 ? 5'(ADDR_BITS_X16) : 5'(ADDR_BITS_X8);
   endfunction

   // Data width for the organisation
   function automatic logic [4:0] data_len(input logic x16);
      data_len = x16 ? 5'(WORD_BITS) : 5'(BYTE_BITS);
   endfunction

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   typedef enum logic [6:0]
   {
      ST_IDLE  = 7'h01,            // Deselected
      ST_SKIP  = 7'h02,            // Waiting for the ignored clock
      ST_START = 7'h04,            // Hunting for the start bit
      ST_OPC   = 7'h08,            // Shifting op-code and address
      ST_DATA  = 7'h10,            // Shifting write data
      ST_READ  = 7'h20,            // Streaming read data
      ST_ARMED = 7'h40             // Waiting for select to drop
   } seep_state_t;

   seep_state_t state;             // Current state
   logic [8:0]  cmd_sr;            // Op-code and address shift
   logic [4:0]  bit_cnt;           // Bits left in the field
   logic [15:0] data_sr;           // Data in or out shift
   logic [4:0]  ptr;               // Array pointer, byte units for x8, word units for x16
   logic [3:0]  pend_op;           // Instruction waiting for deselect
   logic [4:0]  pend_addr;         // Address waiting for deselect
   logic        pend_valid;        // An instruction is armed
   logic        prog_en;           // Write-enable latch
   logic        busy;              // Self-timed cycle running
   logic        x16;               // Organisation caught at start

   // Memory as 32 bytes; a word occupies bytes 2n (high) and 2n+1 (low)
   logic [7:0]  mem [BYTE_COUNT];

   logic [3:0]  opc;               // Decoded op-code
   logic [4:0]  addr;              // Decoded address
   logic [8:0]  next_cmd;          // Command shift after this bit
   assign next_cmd = {cmd_sr[7:0], din_s};
   assign opc  = x16 ? next_cmd[7:4] : next_cmd[8:5];
   assign addr = x16 ? {1'b0, next_cmd[3:0]} : next_cmd[4:0];

   // Read datum at pointer for current organisation
   function automatic logic [15:0] fetch(input logic [4:0] p, input logic w);
      logic [4:0] b;
      b = {p[3:0], 1'b0};
      if (w)
         fetch = {mem[b], mem[b | 5'h01]};
      else
         fetch = {mem[p], 8'h00};    // Byte left-aligned
   endfunction

   // Instruction decoder and serial sequencer
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state      <= ST_IDLE;
         cmd_sr     <= 9'h000;
         bit_cnt    <= 5'h00;
         data_sr    <= 16'h0000;
         ptr        <= 5'h00;
         pend_op    <= 4'h0;
         pend_addr  <= 5'h00;
         pend_valid <= 1'b0;
         x16        <= 1'b1;
         sel_d      <= 1'b0;
      end
      else if (ce_i)
      begin
         sel_d <= sel_s;
         if (!sel_s)
         begin
            // Deselect abandons partial instruction
            state      <= ST_IDLE;
            pend_valid <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
                  state <= ST_SKIP;
               ST_SKIP:
                  if (sck_rise)
                     state <= ST_START;
               ST_START:
                  if (sck_rise && din_s && !busy)
                  begin
                     // Start bit; busy device ignores input
                     state   <= ST_OPC;
                     x16     <= org_s;
                     cmd_sr  <= 9'h000;
                     bit_cnt <= 5'(OPCODE_BITS) + addr_len(org_s);
                  end
               ST_OPC:
                  if (sck_rise)
                  begin
                     cmd_sr  <= next_cmd;
                     bit_cnt <= bit_cnt - 5'h01;
                     if (bit_cnt == 5'h01)
                     begin
                        pend_op   <= opc;
                        pend_addr <= addr;
                        if (opc[3:2] == OP_READ)
                        begin
                           // Load shift register with data; one extra count gives the dummy zero first
                           state   <= ST_READ;
                           ptr     <= addr;
                           data_sr <= fetch(addr, x16);
                           bit_cnt <= data_len(x16) + 5'h01;
                        end
                        else if (opc[3:2] == OP_WRITE || opc == OP_FILL_ALL)
                        begin
                           state   <= ST_DATA;
                           bit_cnt <= data_len(x16);
                        end
                        else
                        begin
                           state      <= ST_ARMED;
                           pend_valid <= 1'b1;
                        end
                     end
                  end
               ST_DATA:
                  if (sck_rise)
                  begin
                     data_sr <= {data_sr[14:0], din_s};
                     bit_cnt <= bit_cnt - 5'h01;
                     if (bit_cnt == 5'h01)
                     begin
                        state      <= ST_ARMED;
                        pend_valid <= 1'b1;
                     end
                  end
               ST_READ:
                  if (sck_rise)
                  begin
                     if (bit_cnt == 5'h01)
                     begin
                        // Next location, wrapping at top, no dummy
                        ptr     <= x16 ? {1'b0, ptr[3:0] + 4'h1} : ptr + 5'h01;
                        data_sr <= fetch(x16 ? {1'b0, ptr[3:0] + 4'h1} : ptr + 5'h01, x16);
                        bit_cnt <= data_len(x16);
                     end
                     else
                     begin
                        if (bit_cnt != data_len(x16) + 5'h01)
                           data_sr <= {data_sr[14:0], 1'b0};
                        bit_cnt <= bit_cnt - 5'h01;
                     end
                  end
               ST_ARMED:
                  ;                         // Extra clocks ignored
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Write-enable latch
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prog_en <= 1'b0;
      else if (ce_i && sel_fall && pend_valid)
      begin
         if (pend_op == OP_PROG_EN)
            prog_en <= 1'b1;
         else if (pend_op == OP_PROG_DIS)
            prog_en <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Self-timed programming and array update
   // ------------------------------------------------------------
   logic [PROG_CNT_BITS-1:0] prog_cnt;  // Cycle countdown
   logic                     go;        // Programming starts now
   assign go = sel_fall && pend_valid && prog_en &&
               (pend_op[3:2] != 2'h0 || pend_op == OP_ERASE_ALL || pend_op == OP_FILL_ALL);

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy     <= 1'b0;
         prog_cnt <= '0;
         for (int i = 0; i < BYTE_COUNT; i++)
            mem[i] <= ERASED_BYTE;
      end
      else if (ce_i)
      begin
         if (go)
         begin
            busy     <= 1'b1;
            prog_cnt <= PROG_CNT_BITS'(PROG_CYCLES_P - 1);
            for (int i = 0; i < BYTE_COUNT; i++)
            begin
               if (pend_op == OP_ERASE_ALL)
                  mem[i] <= ERASED_BYTE;
               else if (pend_op == OP_FILL_ALL)
                  mem[i] <= mem[i] & (x16 ? ((i % 2) == 0 ? data_sr[15:8] : data_sr[7:0])
                                          : data_sr[7:0]);
               else if (x16 ? (i / 2 == int'(pend_addr[3:0])) : (i == int'(pend_addr)))
               begin
                  if (pend_op[3:2] == OP_ERASE)
                     mem[i] <= ERASED_BYTE;
                  else
                     mem[i] <= x16 ? ((i % 2) == 0 ? data_sr[15:8] : data_sr[7:0])
                                   : data_sr[7:0];
               end
            end
         end
         else if (busy)
         begin
            if (prog_cnt == '0)
               busy <= 1'b0;
            else
               prog_cnt <= prog_cnt - PROG_CNT_BITS'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Output drivers
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dout_o    <= 1'b0;
         dout_oe_o <= 1'b0;
         busy_o    <= 1'b0;
      end
      else if (ce_i)
      begin
         busy_o <= busy;
         if (!sel_s)
         begin
            dout_oe_o <= 1'b0;
            dout_o    <= 1'b0;
         end
         else if (state == ST_READ)
         begin
            dout_oe_o <= 1'b1;
            dout_o    <= (bit_cnt == data_len(x16) + 5'h01) ? 1'b0 : data_sr[15];
         end
         else if (state == ST_START || state == ST_SKIP)
         begin
            // Status until a start bit is decoded
            dout_oe_o <= 1'b1;
            dout_o    <= ~busy;
         end
         else
         begin
            dout_oe_o <= 1'b0;
            dout_o    <= 1'b0;
         end
      end
   end

endmodule

// file: seep_core_sva.sv
// Concurrent checks on the ports of the serial EEPROM instruction port
`timescale 1ns/100ps
module seep_core_sva
#(
   parameter int PROG_CYCLES_P = seep_pkg::PROG_CYCLES  // Self-timed cycle length in clocks
)
(
   input wire logic clock_i,    // Core clock
   input wire logic rst_n_i,    // Reset, active low
   input wire logic select_i,   // Chip select
   input wire logic sclk_i,     // Serial clock
   input wire logic dout_o,     // Data-out level
   input wire logic dout_oe_o,  // Data-out enable
   input wire logic busy_o      // Self-timed cycle flag
);
   logic        sclk_q;      // Serial clock, one cycle late
   logic [3:0]  since_rise;  // Cycles since a serial clock rise
   logic [31:0] run_len;     // Length of the present busy run
   logic [3:0]  calm;        // History of selected and idle
   logic        sel_q;       // Select, one cycle late
   logic [3:0]  since_sel;   // Cycles since a select rise
   //--------------------------------------------------
   // Helper logic
   //--------------------------------------------------
   // Edge age, busy run length and calm history
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sclk_q     <= 1'b0;
         since_rise <= 4'hf;
         run_len    <= 32'h0;
         calm       <= 4'h0;
         sel_q      <= 1'b0;
         since_sel  <= 4'hf;
      end
      else
      begin
         sclk_q     <= sclk_i;
         since_rise <= (sclk_i && !sclk_q) ? 4'h0 : ((since_rise == 4'hf) ? 4'hf : since_rise + 4'h1);
         run_len    <= busy_o ? run_len + 32'h1 : 32'h0;
         calm       <= {calm[2:0], select_i && !busy_o};
         sel_q      <= select_i;
         since_sel  <= (select_i && !sel_q) ? 4'h0 : ((since_sel == 4'hf) ? 4'hf : since_sel + 4'h1);
      end
   end
   //--------------------------------------------------
   // Properties
   //--------------------------------------------------
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_deselected; !select_i [*8]; endsequence
   sequence s_busy_run; busy_o [*8]; endsequence
   property p_float; s_deselected |-> !dout_oe_o; endproperty
   property p_oe_sel; $rose(dout_oe_o) |-> select_i; endproperty
   property p_oe_clk; $rose(dout_oe_o) |-> since_rise < 4'h8 || since_sel < 4'h8; endproperty
   property p_status; $rose(select_i) |-> ##[1:8] dout_oe_o; endproperty
   property p_quiet; $rose(rst_n_i) |-> !busy_o && !dout_oe_o; endproperty
   property p_busy_start; $rose(busy_o) |-> !$past(select_i) ##0 s_busy_run; endproperty
   property p_busy_len; $fell(busy_o) |-> run_len == PROG_CYCLES_P; endproperty
   property p_busy_bound; $rose(busy_o) |-> ##[1:1000] !busy_o; endproperty
   property p_busy_low; busy_o && dout_oe_o |-> !dout_o; endproperty
   property p_dout_edge; $changed(dout_o) && dout_oe_o && $past(dout_oe_o) && calm == 4'hf |-> since_rise < 4'h8;
   endproperty
   a_float: assert property (p_float) else $error("data-out driven while deselected");
   a_oe_sel: assert property (p_oe_sel) else $error("data-out enabled without select");
   a_oe_clk: assert property (p_oe_clk) else $error("data-out enabled without a clock or select rise");
   a_status: assert property (p_status) else $error("status not shown after select");
   a_quiet: assert property (p_quiet) else $error("active outputs after reset");
   a_busy_start: assert property (p_busy_start) else $error("cycle not started by deselect");
   a_busy_len: assert property (p_busy_len) else $error("self-timed cycle length wrong");
   a_busy_bound: assert property (p_busy_bound) else $error("self-timed cycle too long");
   a_busy_low: assert property (p_busy_low) else $error("busy status not low");
   a_dout_edge: assert property (p_dout_edge) else $error("data-out moved off a clock rise");
endmodule
bind seep_core seep_core_sva #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .select_i(select_i), .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .busy_o(busy_o));

// file: seep_core_tb_top.sv
// Self-checking testbench for the serial EEPROM instruction port
`timescale 1ns/100ps
module seep_core_tb_top;
   import seep_pkg::*;
   localparam int PROG_P = 200;  // Shortened self-timed cycle
   logic clock_i, rst_n_i, ce, org, test_pin;  // Bench-driven inputs
   logic select, sclk, din, dout, dout_oe, busy;  // Pins
   int   fails, checks_done;                   // Counters
   seep_core #(.PROG_CYCLES_P(PROG_P)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .select_i(select),
      .sclk_i(sclk), .din_i(din), .org_i(org), .unused_test_pin_i(test_pin), .dout_o(dout),
      .dout_oe_o(dout_oe), .busy_o(busy));
   seep_host host (.clock_i(clock_i), .dout_i(dout_oe ? dout : ~dout), .select_o(select), .sclk_o(sclk),
      .din_o(din));
   //--------------------------------------------------
   // Shared tasks
   //--------------------------------------------------
   // Compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Bounded wait for the self-timed cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000)
      begin
         @(posedge clock_i);
         n++;
      end
      if (n == 1000)
      begin
         fails++;
         results();
      end
   endtask
   // Start bit, op-code, address, optional data; frame left open
   task automatic instr(input logic o, input logic [3:0] op, input logic [4:0] a, input logic [15:0] d, input int nd);
      logic [63:0] q;
      org <= o;
      host.open_frame();
      host.shift({59'h0, 1'b1, op}, 5, q);
      host.shift({59'h0, a}, o ? 4 : 5, q);
      if (nd > 0)
         host.shift({48'h0, d}, nd, q);
   endtask
   // Whole instruction, then wait out any cycle
   task automatic prog(input logic o, input logic [3:0] op, input logic [4:0] a, input logic [15:0] d, input int nd);
      instr(o, op, a, d, nd);
      host.close_frame();
      wait_idle();
   endtask
   // Read two units after the dummy bit and compare
   task automatic rd(input logic o, input logic [4:0] a, input logic [63:0] exp);
      logic [63:0] q;
      instr(o, 4'b1011, a, 16'h0, 0);
      host.shift(64'h0, o ? 33 : 17, q);
      host.close_frame();
      chk(q, exp);
   endtask
   //--------------------------------------------------
   // Scenarios
   //--------------------------------------------------
   // Enable lost by a second reset
   task automatic t_locked();
      prog(0, 4'b0011, 5'h00, 16'h0, 0);
      rst_n_i <= 1'b0;
      host.tick(5);
      rst_n_i <= 1'b1;
      host.tick(1);
      prog(0, 4'b0110, 5'h03, 16'h00, 8);
      rd(0, 5'h03, {47'h0, 1'b0, 8'hff, 8'hff});
      $display("test locked done");
   endtask
   // Write with status, wrap and both organisations
   task automatic t_write();
      logic b;
      prog(0, 4'b0011, 5'h00, 16'h0, 0);
      instr(0, 4'b0110, 5'h1f, 16'h3c, 8);
      host.close_frame();
      host.open_frame();
      host.pulse(1'b1, b);
      host.pulse(1'b1, b);
      chk({dout_oe, b}, 2'b10);
      wait_idle();
      host.pulse(1'b0, b);
      host.pulse(1'b0, b);
      chk({dout_oe, b}, 2'b11);
      host.close_frame();
      prog(0, 4'b0101, 5'h00, 16'ha5, 8);
      rd(0, 5'h1f, {47'h0, 1'b0, 8'h3c, 8'ha5});
      rd(1, 5'h0f, {31'h0, 1'b0, 16'hff3c, 16'ha5ff});
      $display("test write done");
   endtask
   // Erase and write over programmed cells
   task automatic t_erase();
      prog(0, 4'b1101, 5'h1f, 16'h0, 0);
      prog(0, 4'b0111, 5'h00, 16'h5a, 8);
      rd(0, 5'h1f, {47'h0, 1'b0, 8'hff, 8'h5a});
      $display("test erase done");
   endtask
   // Whole-array erase and fill
   task automatic t_all();
      prog(1, 4'b0010, 5'h00, 16'h0, 0);
      prog(1, 4'b0001, 5'h00, 16'h3cc3, 16);
      prog(1, 4'b0001, 5'h00, 16'hf00f, 16);
      rd(1, 5'h07, {31'h0, 1'b0, 16'h3003, 16'h3003});
      prog(0, 4'b0010, 5'h00, 16'h0, 0);
      rd(0, 5'h1e, {47'h0, 1'b0, 8'hff, 8'hff});
      $display("test all done");
   endtask
   // Write cut short by deselect
   task automatic t_abort();
      instr(0, 4'b0110, 5'h04, 16'h0, 4);
      host.close_frame();
      chk({dout_oe, busy}, 2'b00);
      rd(0, 5'h04, {47'h0, 1'b0, 8'hff, 8'hff});
      $display("test abort done");
   endtask
   // Disabled programming does nothing, reads still work
   task automatic t_off();
      prog(0, 4'b0000, 5'h00, 16'h0, 0);
      prog(0, 4'b0110, 5'h02, 16'h00, 8);
      rd(0, 5'h02, {47'h0, 1'b0, 8'hff, 8'hff});
      $display("test off done");
   endtask
   //--------------------------------------------------
   // Clock and main sequence
   //--------------------------------------------------
   // 100 MHz core clock
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // Reset, then scenarios
   initial
   begin
      rst_n_i     = 1'b0;
      ce          = 1'b1;
      org         = 1'b0;
      test_pin    = 1'b0;
      fails       = 0;
      checks_done = 0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      t_locked();
      t_write();
      t_erase();
      t_all();
      t_abort();
      t_off();
      results();
   end
endmodule

// file: seep_host.sv
// Host controller model driving select, serial clock and data-in
`timescale 1ns/100ps
module seep_host
(
   input  wire logic clock_i,   // Core clock, paces the serial clock
   input  wire logic dout_i,    // Device data-out
   output logic      select_o,  // Chip select
   output logic      sclk_o,    // Serial clock, still between frames
   output logic      din_o      // Serial data-in
);
   localparam int HALF = 8;  // Core clocks per phase, 160 ns period
   // Idle lines at time zero
   initial
   begin
      select_o = 1'b0;
      sclk_o   = 1'b0;
      din_o    = 1'b0;
   end
   // Wait core clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // One serial pulse; data-out is taken just before the rise
   task automatic pulse(input logic d, output logic q);
      din_o <= d;
      tick(HALF);
      q = dout_i;  // Separate data wires, no contention
      sclk_o <= 1'b1;
      tick(HALF);
      sclk_o <= 1'b0;
   endtask
   // Shift n bits MSB first, collecting data-out
   task automatic shift(input logic [63:0] v, input int n, output logic [63:0] q);
      logic b;
      q = 64'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         pulse(v[i], b);
         q = {q[62:0], b};
      end
   endtask
   // Select, then the ignored first pulse with data-in low
   task automatic open_frame();
      logic b;
      select_o <= 1'b1;
      tick(HALF);
      pulse(1'b0, b);
   endtask
   // Deselect before the next rise; data-in stops holding its value
   task automatic close_frame();
      select_o <= 1'b0;
      din_o    <= ~din_o;
      tick(30);
   endtask
endmodule

// file: seep_pkg.sv
// Package of constants for the serial EEPROM instruction port
package seep_pkg;
   localparam int        BYTE_COUNT      = 32;        // Locations in x8 organisation
   localparam int        WORD_COUNT      = 16;        // Locations in x16 organisation
   localparam int        BYTE_BITS       = 8;         // Data bits in x8 organisation
   localparam int        WORD_BITS       = 16;        // Data bits in x16 organisation
   localparam int        ADDR_BITS_X8    = 5;         // Address bits in x8 organisation
   localparam int        ADDR_BITS_X16   = 4;         // Address bits in x16 organisation
   localparam int        OPCODE_BITS     = 4;         // Op-code field width
   localparam logic [1:0] OP_READ        = 2'h2;      // Read, 10XX
   localparam logic [1:0] OP_WRITE       = 2'h1;      // Single write, 01XX
   localparam logic [1:0] OP_ERASE       = 2'h3;      // Single erase, 11XX
   localparam logic [3:0] OP_PROG_EN     = 4'h3;      // program_enable_cmd
   localparam logic [3:0] OP_PROG_DIS    = 4'h0;      // program_disable_cmd
   localparam logic [3:0] OP_ERASE_ALL   = 4'h2;      // erase_entire_cmd
   localparam logic [3:0] OP_FILL_ALL    = 4'h1;      // fill_entire_cmd
   localparam logic [7:0] ERASED_BYTE    = 8'hff;     // Erased cell content
   localparam int        CLK_PERIOD_NS   = 10;        // Core clock period
   localparam int        PROG_TIME_MS    = 10;        // Longest self-timed cycle
   localparam int        PROG_CYCLES     = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int        PROG_CNT_BITS   = 20;        // Width of the cycle counter
endpackage

// file: seep_sync.sv
// Two-flop synchroniser for one input level
`timescale 1ns/100ps
module seep_sync
(
   input  wire logic clock_i,   // Core clock
   input  wire logic rst_n_i,   // Asynchronous reset, active low
   input  wire logic ce_i,      // Clock enable
   input  wire logic async_i,   // Level from outside the domain
   output logic      sync_o     // Level in the core domain
);
   logic stage1;                // First stage, read only by the second

   // Two stages in series
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1 <= 1'b0;
         sync_o <= 1'b0;
      end
      else if (ce_i)
      begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule
